// ---- src/rslhc_pkg.sv ----
package rslhc_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] RSLHC_ADDR_SELECT = 8'h00;
  localparam logic [7:0] RSLHC_ADDR_REFEN = 8'h01;
  localparam logic [7:0] RSLHC_ADDR_HOLD = 8'h02;
  localparam logic [7:0] RSLHC_ADDR_FIXTUNE = 8'h03;
  localparam logic [7:0] RSLHC_ADDR_LD1CNT = 8'h04;
  localparam logic [7:0] RSLHC_ADDR_LD2CNT = 8'h05;
  localparam logic [7:0] RSLHC_ADDR_STMUX = 8'h06;
  localparam logic [7:0] RSLHC_ADDR_TUNEMULT = 8'h07;
  localparam logic [7:0] RSLHC_ADDR_TUNEDIV = 8'h08;
  localparam logic [7:0] RSLHC_ADDR_READBACK = 8'h09;
  localparam logic [7:0] RSLHC_ADDR_STATUS = 8'h0a;
  localparam logic [7:0] RSLHC_ADDR_HOLDEXIT = 8'h0b;
  // select register fields
  localparam int RSLHC_SEL_MAN_LSB = 0;
  localparam int RSLHC_SEL_PIN_EN = 2;
  localparam int RSLHC_SEL_AUTO_EN = 3;
  localparam int RSLHC_SEL_INV = 4;
  localparam int RSLHC_SEL_P0TYPE = 5;
  localparam int RSLHC_SEL_P1TYPE = 6;
  localparam int RSLHC_SEL_LOSS_OF_SIGNAL_ENABLE = 7;
  // hold register fields
  localparam int RSLHC_HOLD_EN = 0;
  localparam int RSLHC_HOLD_FIX = 1;
  localparam int RSLHC_HOLD_TRACK = 2;
  localparam int RSLHC_HOLD_LEAVE = 3;
  // reset values
  localparam logic [7:0] RSLHC_SELECT_RST = 8'h00;
  localparam logic [2:0] RSLHC_REFEN_RST = 3'h7;
  localparam logic [3:0] RSLHC_HOLD_RST = 4'h0;
  localparam logic [9:0] RSLHC_TUNE_RST = 10'h200;
  localparam logic [13:0] RSLHC_LDCNT_RST = 14'h0400;
  localparam logic [15:0] RSLHC_MULT_RST = 16'h0004;
  localparam logic [7:0] RSLHC_DIV_RST = 8'h01;
  localparam logic [1:0] RSLHC_MAN_HOLD = 2'h3;
  // status pin source codes
  typedef enum logic [2:0] {
    RSLHC_SRC_OUTER = 3'h0,
    RSLHC_SRC_INNER = 3'h1,
    RSLHC_SRC_BOTH = 3'h2,
    RSLHC_SRC_HOLD = 3'h3,
    RSLHC_SRC_CAPTURE = 3'h4
  } rslhc_src_t;
  // holdover state
  typedef enum logic [1:0] {
    RSLHC_ST_RUN = 2'b01,
    RSLHC_ST_HOLD = 2'b10
  } rslhc_state_t;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rslhc_bus_t;
endpackage : rslhc_pkg

// ---- src/rslhc_ctrl.sv ----
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rslhc_ctrl
  import rslhc_pkg::*;
#(
  parameter int TUNE_W = 10,
  parameter int CNT_W = 14
) (
  input wire logic clk,
  input wire logic resetn,
  input wire rslhc_bus_t bus,
  output logic [15:0] rdata,
  input wire logic [2:0] ref_loss,
  input wire logic select_pin_0,
  input wire logic select_pin_1,
  input wire logic status_pin_1_in,
  input wire logic outer_pd_tick,
  input wire logic outer_in_window,
  input wire logic inner_pd_tick,
  input wire logic inner_in_window,
  input wire logic [TUNE_W-1:0] outer_tune_sample,
  output logic [1:0] active_ref,
  output logic [2:0] ref_buffer_on,
  output logic outer_pump_tristate,
  output logic [TUNE_W-1:0] outer_loop_tune_output,
  output logic tune_drive,
  output logic status_pin_1,
  output logic status_pin_1_oe,
  output logic status_pin_2
);
  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [7:0] sel_cfg;
  logic [2:0] ref_input_enable;
  logic [3:0] hold_cfg;
  logic [TUNE_W-1:0] fixed_tune_value;
  logic [CNT_W-1:0] loop1_lock_count_target;
  logic [CNT_W-1:0] loop2_lock_count_target;
  logic [2:0] status1_source_select;
  logic [2:0] status2_source_select;
  logic [15:0] tune_update_multiplier;
  logic [7:0] tune_update_divider;
  logic host_exit;
  logic s0_a, s0_b, s1_a, s1_b, st_a, st_b;
  logic [2:0] loss_a, loss_b;
  logic [CNT_W-1:0] cnt1, cnt2;
  logic outer_lock, inner_lock, inner_kept;
  logic [TUNE_W-1:0] tracked;
  logic tune_capture_done;
  logic [23:0] upd_cnt;
  rslhc_state_t state;
  logic [1:0] next_ref;
  logic hold_req;
  logic in_hold;

  // ************************************************************
  // selection mode decode
  // ************************************************************
  wire logic manual_mode = !sel_cfg[RSLHC_SEL_AUTO_EN] && !sel_cfg[RSLHC_SEL_PIN_EN];
  wire logic pin_mode = !sel_cfg[RSLHC_SEL_AUTO_EN] && sel_cfg[RSLHC_SEL_PIN_EN];
  wire logic auto_mode = sel_cfg[RSLHC_SEL_AUTO_EN];
  wire logic [1:0] man_choice = sel_cfg[RSLHC_SEL_MAN_LSB +: 2];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_cfg <= RSLHC_SELECT_RST;
      ref_input_enable <= RSLHC_REFEN_RST;
      hold_cfg <= RSLHC_HOLD_RST;
      fixed_tune_value <= RSLHC_TUNE_RST;
      loop1_lock_count_target <= RSLHC_LDCNT_RST;
      loop2_lock_count_target <= RSLHC_LDCNT_RST;
      status1_source_select <= RSLHC_SRC_OUTER;
      status2_source_select <= RSLHC_SRC_INNER;
      tune_update_multiplier <= RSLHC_MULT_RST;
      tune_update_divider <= RSLHC_DIV_RST;
    end else if (bus.wr) begin
      unique case (bus.addr)
        RSLHC_ADDR_SELECT: sel_cfg <= bus.wdata[7:0];
        RSLHC_ADDR_REFEN: ref_input_enable <= bus.wdata[2:0];
        RSLHC_ADDR_HOLD: hold_cfg <= bus.wdata[3:0];
        RSLHC_ADDR_FIXTUNE: fixed_tune_value <= bus.wdata[TUNE_W-1:0];
        RSLHC_ADDR_LD1CNT: loop1_lock_count_target <= bus.wdata[CNT_W-1:0];
        RSLHC_ADDR_LD2CNT: loop2_lock_count_target <= bus.wdata[CNT_W-1:0];
        RSLHC_ADDR_STMUX: begin
          status1_source_select <= bus.wdata[2:0];
          status2_source_select <= bus.wdata[6:4];
        end
        RSLHC_ADDR_TUNEMULT: tune_update_multiplier <= bus.wdata;
        RSLHC_ADDR_TUNEDIV: tune_update_divider <= bus.wdata[7:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // host exit strobe
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_exit <= 1'b0;
    end else begin
      host_exit <= bus.wr && (bus.addr == RSLHC_ADDR_HOLDEXIT);
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        RSLHC_ADDR_SELECT: rdata <= {8'h00, sel_cfg};
        RSLHC_ADDR_REFEN: rdata <= {13'h0000, ref_input_enable};
        RSLHC_ADDR_HOLD: rdata <= {12'h000, hold_cfg};
        RSLHC_ADDR_FIXTUNE: rdata <= 16'(fixed_tune_value);
        RSLHC_ADDR_LD1CNT: rdata <= 16'(loop1_lock_count_target);
        RSLHC_ADDR_LD2CNT: rdata <= 16'(loop2_lock_count_target);
        RSLHC_ADDR_STMUX: rdata <= {9'h000, status2_source_select, 1'b0, status1_source_select};
        RSLHC_ADDR_TUNEMULT: rdata <= tune_update_multiplier;
        RSLHC_ADDR_TUNEDIV: rdata <= {8'h00, tune_update_divider};
        RSLHC_ADDR_READBACK: rdata <= 16'(outer_loop_tune_output);
        RSLHC_ADDR_STATUS: rdata <= {9'h000, tune_capture_done, in_hold, inner_lock, outer_lock, 1'b0, active_ref};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {s0_a, s0_b, s1_a, s1_b, st_a, st_b} <= 6'h00;
      loss_a <= 3'h7;
      loss_b <= 3'h7;
    end else begin
      s0_a <= select_pin_0;
      s0_b <= s0_a;
      s1_a <= select_pin_1;
      s1_b <= s1_a;
      st_a <= status_pin_1_in;
      st_b <= st_a;
      loss_a <= ref_loss;
      loss_b <= loss_a;
    end
  end

  // ************************************************************
  // reference selection
  // ************************************************************
  logic [1:0] pin_code;
  logic pin_hold;
  always_comb begin
    pin_code = {sel_cfg[RSLHC_SEL_P1TYPE] & s1_b, sel_cfg[RSLHC_SEL_P0TYPE] & s0_b};
    if (sel_cfg[RSLHC_SEL_INV]) begin
      pin_code = ~pin_code;
    end
    // status pin 1 high (low when inverted) requests holdover in pin mode
    pin_hold = st_b ^ sel_cfg[RSLHC_SEL_INV];
  end

  logic [2:0] eligible;
  always_comb begin
    eligible = ref_input_enable & ~loss_b;
    next_ref = active_ref;
    hold_req = 1'b0;
    if (manual_mode) begin
      if (man_choice == RSLHC_MAN_HOLD) begin
        hold_req = 1'b1;
      end else begin
        next_ref = man_choice;
      end
    end else if (pin_mode) begin
      if (pin_code == RSLHC_MAN_HOLD || pin_hold) begin
        hold_req = 1'b1;
      end else begin
        next_ref = pin_code;
      end
    end else if (sel_cfg[RSLHC_SEL_LOSS_OF_SIGNAL_ENABLE] && !hold_cfg[RSLHC_HOLD_LEAVE]) begin
      if (eligible[0]) begin
        next_ref = 2'h0;
      end else if (eligible[1]) begin
        next_ref = 2'h1;
      end else if (eligible[2]) begin
        next_ref = 2'h2;
      end else begin
        hold_req = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_ref <= 2'h0;
    end else begin
      active_ref <= next_ref;
    end
  end

  // ************************************************************
  // reference buffers
  // ************************************************************
  // buffers: enable bits plus forced on for chosen input outside auto mode
  always_comb begin
    ref_buffer_on = ref_input_enable;
    if (!auto_mode && active_ref != RSLHC_MAN_HOLD) begin
      ref_buffer_on[active_ref] = 1'b1;
    end
  end

  // ************************************************************
  // lock detectors
  // ************************************************************
  function automatic logic [CNT_W-1:0] lock_step(input logic [CNT_W-1:0] c, input logic inwin,
                                                 input logic [CNT_W-1:0] tgt);
    if (!inwin) begin
      lock_step = '0;
    end else if (c < tgt) begin
      lock_step = c + 1'b1;
    end else begin
      lock_step = c;
    end
  endfunction : lock_step

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt1 <= '0;
    end else if (outer_pd_tick) begin
      cnt1 <= lock_step(cnt1, outer_in_window, loop1_lock_count_target);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt2 <= '0;
    end else if (inner_pd_tick) begin
      cnt2 <= lock_step(cnt2, inner_in_window, loop2_lock_count_target);
    end
  end

  // ************************************************************
  // lock status
  // ************************************************************
  wire logic outer_det = (cnt1 >= loop1_lock_count_target) && (cnt1 != '0);
  wire logic inner_det = (cnt2 >= loop2_lock_count_target) && (cnt2 != '0);

  // ************************************************************
  // holdover state
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= RSLHC_ST_RUN;
      inner_kept <= 1'b0;
    end else begin
      unique case (state)
        RSLHC_ST_RUN: begin
          if (hold_cfg[RSLHC_HOLD_EN] && hold_req) begin
            state <= RSLHC_ST_HOLD;
            inner_kept <= inner_det;
          end
        end
        RSLHC_ST_HOLD: begin
          if (!hold_cfg[RSLHC_HOLD_EN] || host_exit || !hold_req) begin
            state <= RSLHC_ST_RUN;
          end
        end
        default: state <= RSLHC_ST_RUN;
      endcase
    end
  end

  // ************************************************************
  // holdover outputs
  // ************************************************************
  assign in_hold = (state == RSLHC_ST_HOLD);
  assign outer_lock = outer_det && !in_hold;
  assign inner_lock = in_hold ? (inner_kept || inner_det) : inner_det;
  assign outer_pump_tristate = in_hold;

  // ************************************************************
  // tune tracking
  // ************************************************************
  wire logic [23:0] upd_period = tune_update_multiplier * tune_update_divider;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upd_cnt <= 24'h000000;
      tracked <= RSLHC_TUNE_RST;
      tune_capture_done <= 1'b0;
    end else if (!hold_cfg[RSLHC_HOLD_TRACK]) begin
      upd_cnt <= 24'h000000;
      tune_capture_done <= 1'b0;
    end else if (outer_pd_tick && !in_hold) begin
      if (upd_cnt + 24'h000001 >= upd_period) begin
        upd_cnt <= 24'h000000;
        tracked <= outer_tune_sample;
        tune_capture_done <= 1'b1;
      end else begin
        upd_cnt <= upd_cnt + 24'h000001;
      end
    end
  end

  // ************************************************************
  // tune output
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outer_loop_tune_output <= RSLHC_TUNE_RST;
      tune_drive <= 1'b0;
    end else begin
      tune_drive <= in_hold;
      if (in_hold && hold_cfg[RSLHC_HOLD_FIX]) begin
        outer_loop_tune_output <= fixed_tune_value;
      end else if (in_hold) begin
        outer_loop_tune_output <= tracked;
      end else begin
        outer_loop_tune_output <= outer_tune_sample;
      end
    end
  end

  // ************************************************************
  // status pins
  // ************************************************************
  function automatic logic status_pick(input logic [2:0] s, input logic ol, input logic il,
                                       input logic h, input logic cd);
    unique case (s)
      RSLHC_SRC_OUTER: status_pick = ol;
      RSLHC_SRC_INNER: status_pick = il;
      RSLHC_SRC_BOTH: status_pick = ol & il;
      RSLHC_SRC_HOLD: status_pick = h;
      RSLHC_SRC_CAPTURE: status_pick = cd;
      default: status_pick = 1'b0;
    endcase
  endfunction : status_pick

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_pin_1 <= 1'b0;
      status_pin_2 <= 1'b0;
    end else begin
      status_pin_1 <= status_pick(status1_source_select, outer_lock, inner_lock, in_hold, tune_capture_done);
      status_pin_2 <= status_pick(status2_source_select, outer_lock, inner_lock, in_hold, tune_capture_done);
    end
  end

  // status pin 1 becomes an input in pin select mode
  assign status_pin_1_oe = !pin_mode;
endmodule : rslhc_ctrl

// ---- tb/rslhc_ctrl_properties.sv ----
`timescale 1ns/1ps
module rslhc_ctrl_properties
  import rslhc_pkg::*;
#(
  parameter int TUNE_W = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input wire rslhc_bus_t bus,
  input wire logic [15:0] rdata,
  input wire logic [1:0] active_ref,
  input wire logic outer_pump_tristate,
  input wire logic [TUNE_W-1:0] outer_loop_tune_output,
  input wire logic tune_drive,
  input wire logic status_pin_1_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic st_rd;
  assign st_rd = bus.rd && bus.addr == RSLHC_ADDR_STATUS;
  // ********
  // checks
  // ********
  ref_code_a: assert property (active_ref != 2'h3)
    else $error("reference code three selected");
  drive_cause_a: assert property (tune_drive |-> $past(outer_pump_tristate))
    else $error("tune drive outside holdover");
  hold_drive_a: assert property (outer_pump_tristate ##1 outer_pump_tristate |-> tune_drive)
    else $error("tune drive late in holdover");
  drive_steady_a: assert property (tune_drive && $past(tune_drive) |-> $stable(outer_loop_tune_output))
    else $error("tune output moved in holdover");
  rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data without read");
  status_ref_a: assert property (st_rd |=> rdata[1:0] == $past(active_ref))
    else $error("status shows wrong reference");
  hold_flag_a: assert property (st_rd |=> rdata[5] == $past(outer_pump_tristate))
    else $error("hold status differs from pump state");
  hold_unlock_a: assert property (st_rd && outer_pump_tristate |=> !rdata[3])
    else $error("outer lock shown in holdover");
  cover property (st_rd ##1 rdata[3]);
  cover property ($rose(tune_drive));
  cover property (!status_pin_1_oe);
endmodule : rslhc_ctrl_properties

bind rslhc_ctrl rslhc_ctrl_properties #(.TUNE_W(TUNE_W)) i_rslhc_ctrl_properties (
  .clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .active_ref(active_ref),
  .outer_pump_tristate(outer_pump_tristate), .outer_loop_tune_output(outer_loop_tune_output),
  .tune_drive(tune_drive), .status_pin_1_oe(status_pin_1_oe)
);

// ---- tb/rslhc_loops.sv ----
`timescale 1ns/1ps
module rslhc_loops #(
  parameter int TUNE_W = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic win_o,
  input wire logic win_i,
  output logic outer_pd_tick,
  output logic inner_pd_tick,
  output logic outer_in_window,
  output logic inner_in_window,
  output logic [TUNE_W-1:0] outer_tune_sample
);
  logic [1:0] phase;
  // ********
  // both loops compare every fourth cycle
  // ********
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 2'h0;
      outer_tune_sample <= '0;
    end else begin
      phase <= phase + 2'h1;
      if (outer_pd_tick) begin
        outer_tune_sample <= outer_tune_sample + 1'b1;
      end
    end
  end
  assign outer_pd_tick = phase == 2'h3;
  assign inner_pd_tick = outer_pd_tick;
  // window flags carry no meaning between ticks
  assign outer_in_window = outer_pd_tick ? win_o : !win_o;
  assign inner_in_window = inner_pd_tick ? win_i : !win_i;
endmodule : rslhc_loops

// ---- tb/rslhc_ctrl_tb.sv ----
`timescale 1ns/1ps
module rslhc_ctrl_tb;
  import rslhc_pkg::*;
  logic clk, resetn, s0, s1, st_in, wo, wi, op, ip, ow, iw, pt, dr, p1, oe, p2;
  logic [2:0] loss, bon;
  logic [1:0] ar;
  logic [9:0] smp, tout;
  logic [15:0] rdata, v, w;
  rslhc_bus_t bus;
  int errors, checked;
  rslhc_ctrl i_rslhc_ctrl (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .ref_loss(loss),
    .select_pin_0(s0), .select_pin_1(s1), .status_pin_1_in(st_in), .outer_pd_tick(op),
    .outer_in_window(ow), .inner_pd_tick(ip), .inner_in_window(iw), .outer_tune_sample(smp),
    .active_ref(ar), .ref_buffer_on(bon), .outer_pump_tristate(pt), .outer_loop_tune_output(tout),
    .tune_drive(dr), .status_pin_1(p1), .status_pin_1_oe(oe), .status_pin_2(p2));
  rslhc_loops i_rslhc_loops (.clk(clk), .resetn(resetn), .win_o(wo), .win_i(wi), .outer_pd_tick(op),
    .inner_pd_tick(ip), .outer_in_window(ow), .inner_in_window(iw), .outer_tune_sample(smp));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ********
  // shared tasks
  // ********
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk) bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic tick(input int n);
    repeat (n) @(posedge clk iff op);
    #1;
  endtask : tick
  task automatic close_out;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // ********
  // scenarios
  // ********
  task automatic s_reset;
    logic [7:0] a[6] = '{8'h01, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0c};
    logic [15:0] e[6] = '{16'h7, 16'h400, 16'h400, 16'h4, 16'h1, 16'h0};
    for (int i = 0; i < 6; i++) begin
      rd(a[i], v);
      chk("reset value", v, e[i]);
    end
  endtask : s_reset
  task automatic s_manual;
    wr(RSLHC_ADDR_REFEN, 16'h0);
    for (int c = 0; c < 3; c++) begin
      wr(RSLHC_ADDR_SELECT, 16'(c));
      cyc(3);
      chk("manual ref", ar, 16'(c));
      chk("manual buffer", bon, 16'(3'b001 << c));
    end
  endtask : s_manual
  task automatic s_pin;
    @(posedge clk) s0 <= 1'b1;
    wr(RSLHC_ADDR_SELECT, 16'h64);
    cyc(5);
    chk("pin ref", ar, 16'h1);
    chk("pin buffer", bon[1], 1'b1);
    chk("pin oe", oe, 1'b0);
    @(posedge clk) st_in <= 1'b1;
    wr(RSLHC_ADDR_SELECT, 16'h74);
    cyc(5);
    chk("inverted ref", ar, 16'h2);
  endtask : s_pin
  task automatic s_auto;
    logic [2:0] l[4] = '{3'b000, 3'b001, 3'b011, 3'b010};
    logic [1:0] e[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    wr(RSLHC_ADDR_REFEN, 16'h7);
    wr(RSLHC_ADDR_SELECT, 16'h88);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) loss <= l[i];
      cyc(6);
      chk("auto ref", ar, e[i]);
    end
    wr(RSLHC_ADDR_REFEN, 16'h6);
    cyc(3);
    chk("auto enable", ar, 16'h2);
  endtask : s_auto
  task automatic s_lock;
    wr(RSLHC_ADDR_SELECT, 16'h0);
    wr(RSLHC_ADDR_LD1CNT, 16'h3);
    wr(RSLHC_ADDR_LD2CNT, 16'h2);
    wr(RSLHC_ADDR_STMUX, 16'h20);
    @(posedge clk) wo <= 1'b0;
    wi <= 1'b0;
    tick(1);
    @(posedge clk) wo <= 1'b1;
    wi <= 1'b1;
    tick(2);
    rd(RSLHC_ADDR_STATUS, v);
    chk("inner only", v[4:3], 2'b10);
    tick(1);
    rd(RSLHC_ADDR_STATUS, v);
    chk("both locked", v[4:3], 2'b11);
    chk("pin1 outer", p1, 1'b1);
    chk("pin2 both", p2, 1'b1);
    @(posedge clk) wo <= 1'b0;
    tick(1);
    rd(RSLHC_ADDR_STATUS, v);
    chk("outer cleared", v[4:3], 2'b10);
    chk("pin2 both off", p2, 1'b0);
    @(posedge clk) wo <= 1'b1;
    tick(3);
  endtask : s_lock
  task automatic s_hold;
    wr(RSLHC_ADDR_FIXTUNE, 16'h155);
    wr(RSLHC_ADDR_HOLD, 16'h6);
    wr(RSLHC_ADDR_SELECT, 16'h3);
    cyc(3);
    chk("hold disabled", pt, 1'b0);
    wr(RSLHC_ADDR_HOLD, 16'h7);
    cyc(3);
    chk("hold pump", pt, 1'b1);
    chk("fixed tune", tout, 10'h155);
    chk("drive flag", dr, 1'b1);
    rd(RSLHC_ADDR_STATUS, v);
    chk("hold status", v[5:3], 3'b110);
    wr(RSLHC_ADDR_STMUX, 16'h13);
    cyc(2);
    chk("pin1 hold", p1, 1'b1);
    wr(RSLHC_ADDR_SELECT, 16'h1);
    cyc(3);
    chk("hold left", pt, 1'b0);
    chk("relock ref", ar, 16'h1);
  endtask : s_hold
  task automatic s_exit;
    wr(RSLHC_ADDR_SELECT, 16'h88);
    @(posedge clk) loss <= 3'b111;
    cyc(6);
    chk("loss hold", pt, 1'b1);
    @(posedge clk) loss <= 3'b101;
    cyc(6);
    chk("loss exit", pt, 1'b0);
    chk("exit ref", ar, 16'h1);
  endtask : s_exit
  task automatic s_track;
    wr(RSLHC_ADDR_HOLD, 16'h1);
    wr(RSLHC_ADDR_TUNEMULT, 16'h2);
    wr(RSLHC_ADDR_TUNEDIV, 16'h2);
    wr(RSLHC_ADDR_STMUX, 16'h40);
    wr(RSLHC_ADDR_SELECT, 16'h0);
    cyc(2);
    chk("capture clear", p2, 1'b0);
    wr(RSLHC_ADDR_HOLD, 16'h5);
    tick(3);
    chk("capture early", p2, 1'b0);
    tick(1);
    w = {6'h00, smp - 10'h001};
    tick(2);
    chk("capture flag", p2, 1'b1);
    wr(RSLHC_ADDR_SELECT, 16'h3);
    cyc(3);
    chk("tracked tune", tout, w);
    rd(RSLHC_ADDR_READBACK, v);
    chk("tune readback", v, w);
    wr(RSLHC_ADDR_SELECT, 16'h0);
  endtask : s_track
  initial begin
    resetn = 1'b0;
    bus = '0;
    loss = 3'b000;
    s0 = 1'b0;
    s1 = 1'b0;
    st_in = 1'b0;
    wo = 1'b1;
    wi = 1'b1;
    errors = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    s_reset;
    s_manual;
    s_pin;
    s_auto;
    s_lock;
    s_hold;
    s_exit;
    s_track;
    close_out;
  end
  initial begin
    #500000;
    errors++;
    close_out;
  end
endmodule : rslhc_ctrl_tb
